// ==== cvs_defines.svh ====
/*
  Constants for the crew vigilance sequencer: times, codes and register offsets.
  Assumes inclusion by bare name from the top module.
*/
`ifndef CVS_DEFINES_SVH
`define CVS_DEFINES_SVH
// ==========================================================
// Timing
`define CVS_CLK_HZ 50000000
`define CVS_WIN_S 8'd60
`define CVS_WARN_S 8'd17
`define CVS_PEN_S 8'd34
`define CVS_STUCK_S 8'd60
`define CVS_DEB_MS 10
`define CVS_BAUD 9600
// ==========================================================
// Event log and download
`define CVS_LOG_DEPTH 14'd10000
`define CVS_LOG_LAST 14'd9999
`define CVS_DL_CMD 8'h64
`define CVS_LAST_BYTE 3'd4
`define CVS_EV_PON 0
`define CVS_EV_POFF 1
`define CVS_EV_APPLY 2
`define CVS_EV_REL 3
`define CVS_EV_BYP 4
`define CVS_EV_REACT 5
`define CVS_EV_CFG 6
`define CVS_EV_FAIL 7
// ==========================================================
// Register offsets and fields
`define CVS_A_CTRL 5'h00
`define CVS_A_STATUS 5'h04
`define CVS_A_COUNT 5'h08
`define CVS_A_TIME 5'h0c
`define CVS_A_LOGCNT 5'h10
`define CVS_CTRL_FAULT 0
`define CVS_CTRL_DL 1
`endif

// ==== cvs_pkg.sv ====
/*
  Types shared by the crew vigilance sequencer.
  Assumes cvs_defines.svh is on the include path.
*/
`default_nettype none
package cvs_pkg;
  typedef enum logic [2:0] {
    CVS_WIN, CVS_WARN1, CVS_WARN2, CVS_PEN_FIX, CVS_PEN_LATCH, CVS_FAULT
  } cvs_state_t;
endpackage
`default_nettype wire

// ==== cvs_top.sv ====
/*
  Crew vigilance sequencer: phase machine, lamps, penalty counter, event log,
  serial download and an Avalon-MM register slave.
  Assumes all inputs synchronous to REF_CLK and debouncing done here.
*/
// The address map and the Avalon-MM register port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "cvs_defines.svh"
// Notes on behaviour
// - Sixty second window restarts on any qualifying driver action.
// - Notch, sander, horn, both brakes, dynamic brake and acknowledge qualify.
// - Window expiry enters the first warning phase at once.
// - Acknowledge button unchanged over sixty seconds forces the first warning.
// - First warning: 17 s flashing yellow; acknowledge returns to window.
// - Second warning: 17 s flashing plus buzzer; acknowledge returns to window.
// - Fixed penalty 34 s: brake, red blink, yellow flash, idle demand.
// - Fixed penalty ignores acknowledge and every other reset action.
// - Penalty counter rises by one on each fixed penalty entry.
// - Penalty start logs a time-stamped apply event.
// - Latched penalty ends on idle notch, stopped or braked, and acknowledge.
// - Ending latched penalty releases brake, clears lamps, resumes window.
// - Ending latched penalty logs a time-stamped release event.
// - Both stand switches off suppresses vigilance and lights green trail lamp.
// - Suppression only holds the window, never warning or penalty phases.
// - Braked cylinder or speed under 3 km/h suppresses the window.
// - Bypass stops everything, releases the brake, lights bypass lamp.
// - Bypass on and off are each logged with a time stamp.
// - Log keeps the latest 10000 events of eight types in order.
// - A download request sends the stored log out of the serial port.
// - Serial port runs at 9600 baud.
// - Penalty count drives a five digit seven segment display.
// - Internal fault applies brake and withdraws the idle demand output.
module cvs_top #(
  parameter int unsigned HALF_CYC = `CVS_CLK_HZ / 2,
  parameter int unsigned DEB_CYC = `CVS_CLK_HZ / 1000 * `CVS_DEB_MS,
  parameter int unsigned BAUD_CYC = `CVS_CLK_HZ / `CVS_BAUD
) (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic [4:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic [3:0] NOTCH,
  input wire logic [1:0] SANDER,
  input wire logic [1:0] HORN,
  input wire logic TRAIN_BRAKE_INPUT,
  input wire logic LOCO_BRAKE_INPUT,
  input wire logic [2:0] DYN_BRAKE,
  input wire logic ACK_BUTTON,
  input wire logic STAND_ONE_SWITCH,
  input wire logic STAND_TWO_SWITCH,
  input wire logic BRAKE_CYLINDER_PRESSURE,
  input wire logic SPEED_ZERO,
  input wire logic SPEED_LOW,
  input wire logic BYPASS_SWITCH,
  input wire logic EQUIP_FAULT,
  input wire logic POWER_FAIL,
  input wire logic RXD,
  output logic TXD,
  output logic WARN_LAMP,
  output logic BUZZER,
  output logic PENALTY_BRAKE,
  output logic ENGINE_IDLE_DEMAND,
  output logic ACTIVE_LED,
  output logic BYPASS_LED,
  output logic TRAIL_LED,
  output logic PENALTY_LED,
  output logic [34:0] SEG_DIGITS
);
  import cvs_pkg::*;

  function automatic logic [6:0] cvs_seg(input logic [3:0] d);
    case (d)
      4'h0: cvs_seg = 7'h3f;
      4'h1: cvs_seg = 7'h06;
      4'h2: cvs_seg = 7'h5b;
      4'h3: cvs_seg = 7'h4f;
      4'h4: cvs_seg = 7'h66;
      4'h5: cvs_seg = 7'h6d;
      4'h6: cvs_seg = 7'h7d;
      4'h7: cvs_seg = 7'h07;
      4'h8: cvs_seg = 7'h7f;
      4'h9: cvs_seg = 7'h6f;
      default: cvs_seg = 7'h00;
    endcase
  endfunction

  function automatic logic [13:0] cvs_next_idx(input logic [13:0] i);
    cvs_next_idx = (i == `CVS_LOG_LAST) ? 14'h0 : i + 14'h1;
  endfunction

  // ==========================================================
  // Timebase
  logic [31:0] half_cnt;
  logic half_tick;
  logic sec_phase;
  logic sec_tick;
  logic [31:0] deb_cnt;
  logic deb_tick;

  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      half_cnt <= 32'h0;
      half_tick <= 1'b0;
      sec_phase <= 1'b0;
    end
    else
    begin
      half_tick <= (half_cnt == HALF_CYC - 1);
      half_cnt <= (half_cnt == HALF_CYC - 1) ? 32'h0 : half_cnt + 32'h1;
      if (half_tick)
        sec_phase <= ~sec_phase;
    end
  end
  assign sec_tick = half_tick & sec_phase;

  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      deb_cnt <= 32'h0;
      deb_tick <= 1'b0;
    end
    else
    begin
      deb_tick <= (deb_cnt == DEB_CYC - 1);
      deb_cnt <= (deb_cnt == DEB_CYC - 1) ? 32'h0 : deb_cnt + 32'h1;
    end
  end

  // ==========================================================
  // Debounce and driver actions
  logic [13:0] raw;
  logic [13:0] samp;
  logic [13:0] stable;
  logic [13:0] prev;
  logic action;
  logic ack_press;
  logic ack_change;
  assign raw = {ACK_BUTTON, DYN_BRAKE, LOCO_BRAKE_INPUT, TRAIN_BRAKE_INPUT, HORN, SANDER, NOTCH};

  // A level counts only once it has read the same on two samples 10 ms apart.
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      samp <= 14'h0;
      stable <= 14'h0;
      prev <= 14'h0;
    end
    else
    begin
      if (deb_tick)
      begin
        samp <= raw;
        stable <= (samp ~^ raw) & raw | (samp ^ raw) & stable;
      end
      prev <= stable;
    end
  end
  assign action = |(stable ^ prev);
  assign ack_change = stable[13] ^ prev[13];
  assign ack_press = stable[13] & ~prev[13];

  // ==========================================================
  // Phase machine
  cvs_state_t state;
  cvs_state_t state_q;
  logic [7:0] ph;
  logic [7:0] stuck;
  logic byp_q;
  logic suppress;
  logic trail;
  logic fault_req;
  logic [31:0] ctrl;
  assign trail = ~STAND_ONE_SWITCH & ~STAND_TWO_SWITCH;
  // The pressure input already carries the sensor's own hysteresis.
  assign suppress = trail | BRAKE_CYLINDER_PRESSURE | SPEED_LOW;
  assign fault_req = EQUIP_FAULT | ctrl[`CVS_CTRL_FAULT];

  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
      stuck <= 8'h0;
    else if (ack_change || state != CVS_WIN || BYPASS_SWITCH || suppress)
      stuck <= 8'h0;
    else if (sec_tick && stuck != 8'hff)
      stuck <= stuck + 8'h1;
  end

  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      state <= CVS_WIN;
      ph <= 8'h0;
    end
    else if (BYPASS_SWITCH)
    begin
      state <= CVS_WIN;
      ph <= 8'h0;
    end
    else if (fault_req && state != CVS_FAULT)
      state <= CVS_FAULT;
    else
    begin
      case (state)
        CVS_WIN:
        begin
          if (stuck > `CVS_STUCK_S)
          begin
            state <= CVS_WARN1;
            ph <= 8'h0;
          end
          else if (action || suppress)
            ph <= 8'h0;
          else if (sec_tick && ph == `CVS_WIN_S - 8'h1)
          begin
            state <= CVS_WARN1;
            ph <= 8'h0;
          end
          else if (sec_tick)
            ph <= ph + 8'h1;
        end
        CVS_WARN1, CVS_WARN2:
        begin
          if (ack_press)
          begin
            state <= CVS_WIN;
            ph <= 8'h0;
          end
          else if (sec_tick && ph == `CVS_WARN_S - 8'h1)
          begin
            state <= (state == CVS_WARN1) ? CVS_WARN2 : CVS_PEN_FIX;
            ph <= 8'h0;
          end
          else if (sec_tick)
            ph <= ph + 8'h1;
        end
        CVS_PEN_FIX:
        begin
          // No input is looked at here until the fixed time is over.
          if (sec_tick && ph == `CVS_PEN_S - 8'h1)
          begin
            state <= CVS_PEN_LATCH;
            ph <= 8'h0;
          end
          else if (sec_tick)
            ph <= ph + 8'h1;
        end
        CVS_PEN_LATCH:
        begin
          if (ack_press && stable[3:0] == 4'h0 && (SPEED_ZERO || BRAKE_CYLINDER_PRESSURE))
            state <= CVS_WIN;
        end
        CVS_FAULT:
          state <= CVS_FAULT;
        default:
          state <= CVS_FAULT;
      endcase
    end
  end

  // ==========================================================
  // Outputs and penalty counter
  logic [3:0] bcd [0:4];
  logic [4:0] carry;
  logic ev_apply;
  assign ev_apply = state == CVS_PEN_FIX && state_q != CVS_PEN_FIX;

  // A digit steps only when every digit below it is at nine.
  always_comb
  begin
    carry[0] = 1'b1;
    for (int i = 1; i < 5; i++)
      carry[i] = carry[i - 1] & (bcd[i - 1] == 4'h9);
  end

  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      for (int i = 0; i < 5; i++)
        bcd[i] <= 4'h0;
    end
    else if (ev_apply)
    begin
      for (int i = 0; i < 5; i++)
        if (carry[i])
          bcd[i] <= (bcd[i] == 4'h9) ? 4'h0 : bcd[i] + 4'h1;
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      state_q <= CVS_WIN;
      byp_q <= 1'b0;
      WARN_LAMP <= 1'b0;
      BUZZER <= 1'b0;
      PENALTY_BRAKE <= 1'b0;
      ENGINE_IDLE_DEMAND <= 1'b0;
      ACTIVE_LED <= 1'b0;
      BYPASS_LED <= 1'b0;
      TRAIL_LED <= 1'b0;
      PENALTY_LED <= 1'b0;
      SEG_DIGITS <= 35'h0;
    end
    else
    begin
      state_q <= state;
      byp_q <= BYPASS_SWITCH;
      WARN_LAMP <= sec_phase & (state == CVS_WARN1 || state == CVS_WARN2 || state == CVS_PEN_FIX);
      BUZZER <= state == CVS_WARN2;
      PENALTY_BRAKE <= state == CVS_PEN_FIX || state == CVS_PEN_LATCH || state == CVS_FAULT;
      ENGINE_IDLE_DEMAND <= state == CVS_PEN_FIX || state == CVS_PEN_LATCH;
      ACTIVE_LED <= ~BYPASS_SWITCH & state != CVS_FAULT;
      BYPASS_LED <= BYPASS_SWITCH;
      TRAIL_LED <= trail & ~BYPASS_SWITCH;
      PENALTY_LED <= (state == CVS_PEN_FIX) ? sec_phase : (state == CVS_PEN_LATCH || state == CVS_FAULT);
      SEG_DIGITS <= {cvs_seg(bcd[4]), cvs_seg(bcd[3]), cvs_seg(bcd[2]), cvs_seg(bcd[1]),
                     cvs_seg(bcd[0])};
    end
  end

  // ==========================================================
  // Event capture and log
  logic [7:0] pend;
  logic [7:0] ev;
  logic [7:0] clr;
  logic [2:0] first;
  logic pf_q;
  logic cfg_wr;
  logic [31:0] now;
  logic [34:0] mem [0:9999];
  logic [13:0] wptr;
  logic [13:0] lcnt;

  always_comb
  begin
    ev = 8'h0;
    ev[`CVS_EV_POFF] = POWER_FAIL & ~pf_q;
    ev[`CVS_EV_APPLY] = ev_apply;
    ev[`CVS_EV_REL] = state_q == CVS_PEN_LATCH && state == CVS_WIN && !BYPASS_SWITCH;
    ev[`CVS_EV_BYP] = BYPASS_SWITCH & ~byp_q;
    ev[`CVS_EV_REACT] = ~BYPASS_SWITCH & byp_q;
    ev[`CVS_EV_CFG] = cfg_wr;
    ev[`CVS_EV_FAIL] = state == CVS_FAULT && state_q != CVS_FAULT;
    first = 3'h0;
    for (int i = 7; i >= 0; i--)
      if (pend[i])
        first = 3'(i);
    clr = (pend != 8'h0) ? (8'h1 << first) : 8'h0;
  end

  // Pending bits queue same-cycle events; a new event wins over its own clear.
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      pend <= 8'h1;
      pf_q <= 1'b0;
      wptr <= 14'h0;
      lcnt <= 14'h0;
    end
    else
    begin
      pf_q <= POWER_FAIL;
      pend <= (pend & ~clr) | ev;
      if (pend != 8'h0)
      begin
        wptr <= cvs_next_idx(wptr);
        if (lcnt != `CVS_LOG_DEPTH)
          lcnt <= lcnt + 14'h1;
      end
    end
  end

  // Storage has no reset so it can map onto plain memory cells.
  always_ff @(posedge REF_CLK)
  begin
    if (pend != 8'h0)
      mem[wptr] <= {first, now};
  end

  // ==========================================================
  // Serial download
  logic [31:0] tx_cnt;
  logic [9:0] tx_sh;
  logic [3:0] tx_bits;
  logic dl_busy;
  logic dl_go;
  logic rx_cmd;
  logic [13:0] rptr;
  logic [13:0] left;
  logic [2:0] bidx;
  logic [34:0] ent;
  logic [7:0] byte_out;
  logic ctrl_dl_req;
  assign ent = mem[rptr];
  assign byte_out = (bidx == 3'h0) ? {5'h0, ent[34:32]} : ent[8 * (4 - bidx) +: 8];
  assign dl_go = rx_cmd | (cfg_wr & ctrl_dl_req);

  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      tx_cnt <= 32'h0;
      tx_sh <= 10'h3ff;
      tx_bits <= 4'h0;
      dl_busy <= 1'b0;
      rptr <= 14'h0;
      left <= 14'h0;
      bidx <= 3'h0;
      TXD <= 1'b1;
    end
    else
    begin
      if (dl_go && !dl_busy && lcnt != 14'h0)
      begin
        dl_busy <= 1'b1;
        left <= lcnt;
        rptr <= (wptr >= lcnt) ? wptr - lcnt : wptr + `CVS_LOG_DEPTH - lcnt;
        bidx <= 3'h0;
      end
      tx_cnt <= (tx_cnt == BAUD_CYC - 1) ? 32'h0 : tx_cnt + 32'h1;
      if (tx_cnt == BAUD_CYC - 1)
      begin
        if (tx_bits != 4'h0)
        begin
          TXD <= tx_sh[0];
          tx_sh <= {1'b1, tx_sh[9:1]};
          tx_bits <= tx_bits - 4'h1;
        end
        else if (dl_busy && left != 14'h0)
        begin
          TXD <= 1'b1;
          tx_sh <= {1'b1, byte_out, 1'b0};
          tx_bits <= 4'ha;
          if (bidx == `CVS_LAST_BYTE)
          begin
            bidx <= 3'h0;
            rptr <= cvs_next_idx(rptr);
            left <= left - 14'h1;
          end
          else
            bidx <= bidx + 3'h1;
        end
        else
        begin
          TXD <= 1'b1;
          dl_busy <= 1'b0;
        end
      end
    end
  end

  logic [31:0] rx_cnt;
  logic [3:0] rx_bit;
  logic [7:0] rx_sh;
  logic rx_busy;

  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      rx_cnt <= 32'h0;
      rx_bit <= 4'h0;
      rx_sh <= 8'h0;
      rx_busy <= 1'b0;
      rx_cmd <= 1'b0;
    end
    else
    begin
      rx_cmd <= 1'b0;
      if (!rx_busy)
      begin
        if (!RXD)
        begin
          rx_busy <= 1'b1;
          rx_cnt <= 32'(BAUD_CYC / 2);
          rx_bit <= 4'h0;
        end
      end
      else if (rx_cnt != 32'h0)
        rx_cnt <= rx_cnt - 32'h1;
      else
      begin
        rx_cnt <= 32'(BAUD_CYC - 1);
        rx_bit <= rx_bit + 4'h1;
        if (rx_bit == 4'h0 && RXD)
          rx_busy <= 1'b0;
        else if (rx_bit == 4'h9)
        begin
          rx_busy <= 1'b0;
          rx_cmd <= RXD && rx_sh == `CVS_DL_CMD;
        end
        else if (rx_bit != 4'h0)
          rx_sh <= {RXD, rx_sh[7:1]};
      end
    end
  end

  // ==========================================================
  // Avalon-MM slave: one wait state, then the transfer completes.
  logic take;
  assign take = (AVS_READ | AVS_WRITE) & ~AVS_WAITREQUEST;
  assign cfg_wr = take & AVS_WRITE & (AVS_ADDRESS == `CVS_A_CTRL || AVS_ADDRESS == `CVS_A_TIME);
  assign ctrl_dl_req = AVS_ADDRESS == `CVS_A_CTRL & AVS_BYTEENABLE[0]
                       & AVS_WRITEDATA[`CVS_CTRL_DL];

  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      AVS_WAITREQUEST <= 1'b1;
      AVS_READDATA <= 32'h0;
      ctrl <= 32'h0;
      now <= 32'h0;
    end
    else
    begin
      AVS_WAITREQUEST <= ~((AVS_READ | AVS_WRITE) & AVS_WAITREQUEST);
      if ((AVS_READ | AVS_WRITE) & AVS_WAITREQUEST)
      begin
        case (AVS_ADDRESS)
          `CVS_A_CTRL: AVS_READDATA <= ctrl;
          `CVS_A_STATUS: AVS_READDATA <= {25'h0, dl_busy, suppress, trail, BYPASS_SWITCH, state};
          `CVS_A_COUNT: AVS_READDATA <= {12'h0, bcd[4], bcd[3], bcd[2], bcd[1], bcd[0]};
          `CVS_A_TIME: AVS_READDATA <= now;
          `CVS_A_LOGCNT: AVS_READDATA <= {18'h0, lcnt};
          default: AVS_READDATA <= 32'h0;
        endcase
      end
      if (take && AVS_WRITE && AVS_ADDRESS == `CVS_A_TIME)
      begin
        for (int b = 0; b < 4; b++)
          if (AVS_BYTEENABLE[b])
            now[8 * b +: 8] <= AVS_WRITEDATA[8 * b +: 8];
      end
      else if (sec_tick)
        now <= now + 32'h1;
      if (take && AVS_WRITE && AVS_ADDRESS == `CVS_A_CTRL && AVS_BYTEENABLE[0])
        ctrl[`CVS_CTRL_FAULT] <= AVS_WRITEDATA[`CVS_CTRL_FAULT];
    end
  end
endmodule
`default_nettype wire

// ==== cvs_checker.sv ====
/*
  Checker on the top ports of the crew vigilance sequencer.
  Assumes a bind from the testbench top file and one clock domain.
*/
`timescale 1ns/10ps
`default_nettype none
module cvs_checker (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_READDATA,
  input wire logic AVS_WAITREQUEST,
  input wire logic WARN_LAMP,
  input wire logic BUZZER,
  input wire logic PENALTY_BRAKE,
  input wire logic ENGINE_IDLE_DEMAND,
  input wire logic ACTIVE_LED,
  input wire logic BYPASS_LED,
  input wire logic TRAIL_LED,
  input wire logic [34:0] SEG_DIGITS
);
  logic [2:0] seg_age;
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RST_N);
  // ==========================================================
  // Display age, so a count step just before the brake still counts.
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
      seg_age <= 3'h7;
    else if ($changed(SEG_DIGITS))
      seg_age <= 3'h0;
    else if (seg_age != 3'h7)
      seg_age <= seg_age + 3'h1;
  end
  // ==========================================================
  // Properties
  wait_one_a:
  assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
    else $error("bus request not answered after one wait state");
  wait_pulse_a:
  assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
    else $error("waitrequest low for more than one cycle");
  read_hold_a:
  assert property (AVS_WAITREQUEST && $past(AVS_WAITREQUEST) |-> $stable(AVS_READDATA))
    else $error("read data changed outside a transfer");
  idle_brake_a:
  assert property (ENGINE_IDLE_DEMAND |-> PENALTY_BRAKE && !BUZZER)
    else $error("idle demand without brake or with buzzer");
  buzz_quiet_a:
  assert property (BUZZER |-> !PENALTY_BRAKE && ACTIVE_LED)
    else $error("buzzer outside the second warning");
  bypass_quiet_a:
  assert property (BYPASS_LED && $past(BYPASS_LED) |-> !PENALTY_BRAKE && !WARN_LAMP && !BUZZER)
    else $error("warning or brake active in bypass");
  active_off_a:
  assert property (BYPASS_LED |-> !ACTIVE_LED && !TRAIL_LED)
    else $error("active or trail lamp lit in bypass");
  count_apply_a:
  assert property ($rose(ENGINE_IDLE_DEMAND) |-> seg_age < 3'h3 or ##[1:3] $changed(SEG_DIGITS))
    else $error("penalty count display did not step");
  brake_release_a:
  assert property ($fell(PENALTY_BRAKE) |-> !WARN_LAMP && !BUZZER && !ENGINE_IDLE_DEMAND)
    else $error("warnings left on at brake release");
  cover property ($rose(BUZZER));
  cover property ($rose(ENGINE_IDLE_DEMAND));
  cover property ($fell(PENALTY_BRAKE));
  cover property ($rose(TRAIL_LED));
endmodule
`default_nettype wire

// ==== cvs_cab_model.sv ====
/*
  Cab model: the brake cylinder pressure switch seen by the sequencer.
  Assumes pressure given in tenths of kg/cm2 on the bench clock.
*/
`timescale 1ns/10ps
`default_nettype none
module cvs_cab_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] press_x10,
  output logic bcp_on
);
  // ==========================================================
  // The band between the two levels keeps a wavering gauge from chattering.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      bcp_on <= 1'b0;
    else if (press_x10 > 8'h17)
      bcp_on <= 1'b1;
    else if (press_x10 < 8'h14)
      bcp_on <= 1'b0;
  end
endmodule
`default_nettype wire

// ==== cvs_top_tb.sv ====
/*
  Testbench for the crew vigilance sequencer.
  Assumes a shortened second, debounce and baud time, and the cab model.
*/
`timescale 1ns/10ps
`default_nettype none
module cvs_top_tb;
  logic clk, rst_n, rd, wr, wait_rq, txd, ack, st1, st2, spd0, spdl, byp, brake_cylinder_pressure, pled;
  logic warn, buzz, brake, idle, act, bled, tled, pfail, efault;
  logic [4:0] addr;
  logic [31:0] wdata, rdata, rv;
  logic [12:0] drv;
  logic [34:0] seg;
  logic [7:0] press;
  logic [6:0] outs;
  int n_errors, checks;
  int sh [6] = '{0, 2, 4, 5, 6, 9};
  assign outs = {tled, bled, act, idle, brake, buzz, warn};
  cvs_top #(.HALF_CYC(20), .DEB_CYC(2), .BAUD_CYC(8)) dut_u (
    .REF_CLK(clk), .RST_N(rst_n), .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr),
    .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(4'hf), .AVS_READDATA(rdata),
    .AVS_WAITREQUEST(wait_rq), .NOTCH(drv[12:9]), .SANDER(drv[3:2]), .HORN(drv[1:0]),
    .TRAIN_BRAKE_INPUT(drv[4]), .LOCO_BRAKE_INPUT(drv[5]), .DYN_BRAKE(drv[8:6]),
    .ACK_BUTTON(ack), .STAND_ONE_SWITCH(st1), .STAND_TWO_SWITCH(st2),
    .BRAKE_CYLINDER_PRESSURE(brake_cylinder_pressure), .SPEED_ZERO(spd0), .SPEED_LOW(spdl), .BYPASS_SWITCH(byp),
    .EQUIP_FAULT(efault), .POWER_FAIL(pfail), .RXD(1'b1), .TXD(txd), .WARN_LAMP(warn),
    .BUZZER(buzz), .PENALTY_BRAKE(brake), .ENGINE_IDLE_DEMAND(idle), .ACTIVE_LED(act),
    .BYPASS_LED(bled), .TRAIL_LED(tled), .PENALTY_LED(pled), .SEG_DIGITS(seg));
  cvs_cab_model cab_u (.clk(clk), .rst_n(rst_n), .press_x10(press), .bcp_on(brake_cylinder_pressure));
  // ==========================================================
  // Shared tasks
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check(input logic [34:0] got, input logic [34:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clk);
    addr <= a;
    wdata <= d;
    rd <= !w;
    wr <= w;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (wait_rq !== 1'b0 && n < 50);
    rv = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    check(n < 50, 1'b1);
    if (n >= 50)
      stop_test();
  endtask
  task automatic rchk(input logic [4:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check(rv, e);
  endtask
  task automatic wait_for(input int k, input logic v, input int lim);
    int n = 0;
    while (outs[k] !== v && n < lim)
    begin
      @(negedge clk);
      n++;
    end
    check(outs[k], v);
    if (outs[k] !== v)
      stop_test();
  endtask
  task automatic hold(input int k, input logic v, input int lim);
    logic bad = 1'b0;
    repeat (lim)
    begin
      @(negedge clk);
      if (outs[k] !== v)
        bad = 1'b1;
    end
    check(bad, 1'b0);
  endtask
  task automatic press_ack();
    @(posedge clk);
    ack <= 1'b1;
    repeat (8) @(posedge clk);
    ack <= 1'b0;
    repeat (8) @(posedge clk);
  endtask
  // ==========================================================
  // Scenarios
  task automatic reg_test();
    rchk(5'h04, 32'h0);
    rchk(5'h08, 32'h0);
    rchk(5'h10, 32'h1);
    rchk(5'h14, 32'h0);
    bus(1'b1, 5'h0c, 32'h100);
    rchk(5'h10, 32'h2);
    $display("reg_test done");
  endtask
  task automatic stuck_test();
    press_ack();
    for (int k = 0; k < 6; k++)
    begin
      @(posedge clk);
      drv <= drv ^ (13'h1 << sh[k]);
      hold(0, 1'b0, 350);
    end
    @(posedge clk);
    drv <= drv ^ 13'h1;
    wait_for(0, 1'b1, 800);
    check(buzz, 1'b0);
    press_ack();
    rchk(5'h04, 32'h0);
    $display("stuck_test done");
  endtask
  task automatic penalty_test();
    int n0;
    bus(1'b0, 5'h10, 32'h0);
    n0 = rv;
    wait_for(0, 1'b1, 2600);
    wait_for(1, 1'b1, 800);
    wait_for(2, 1'b1, 800);
    check(outs[3:1], 3'h6);
    press_ack();
    rchk(5'h04, 32'h3);
    rchk(5'h08, 32'h1);
    rchk(5'h10, n0 + 1);
    check(seg[13:0], 14'h1f86);
    repeat (1400) @(posedge clk);
    rchk(5'h04, 32'h4);
    @(posedge clk);
    spd0 <= 1'b1;
    press_ack();
    rchk(5'h04, 32'h4);
    @(posedge clk);
    drv[12:9] <= 4'h0;
    repeat (8) @(posedge clk);
    press_ack();
    check(brake, 1'b0);
    bus(1'b0, 5'h04, 32'h0);
    check(rv[2:0], 3'h0);
    rchk(5'h10, n0 + 2);
    spd0 <= 1'b0;
    $display("penalty_test done");
  endtask
  task automatic suppress_test();
    @(posedge clk);
    {st1, st2} <= 2'h0;
    hold(0, 1'b0, 2800);
    check(tled, 1'b1);
    @(posedge clk);
    {st1, st2} <= 2'h3;
    press <= 8'h19;
    hold(0, 1'b0, 2800);
    @(posedge clk);
    press <= 8'h15;
    hold(0, 1'b0, 2800);
    @(posedge clk);
    press <= 8'h0;
    wait_for(0, 1'b1, 2600);
    @(posedge clk);
    spdl <= 1'b1;
    wait_for(1, 1'b1, 800);
    press_ack();
    spdl <= 1'b0;
    $display("suppress_test done");
  endtask
  task automatic dl_test();
    int n = 0;
    logic [7:0] b = 8'hff;
    bus(1'b1, 5'h00, 32'h2);
    while (txd !== 1'b0 && n < 40)
    begin
      @(negedge clk);
      n++;
    end
    check(n < 40, 1'b1);
    repeat (4) @(negedge clk);
    for (int i = 0; i < 8; i++)
    begin
      repeat (8) @(negedge clk);
      b[i] = txd;
    end
    check(b, 8'h00);
    repeat (8) @(negedge clk);
    check(txd, 1'b1);
    bus(1'b0, 5'h10, 32'h0);
    n = rv;
    @(posedge clk);
    pfail <= 1'b1;
    repeat (3) @(posedge clk);
    rchk(5'h10, n + 1);
    pfail <= 1'b0;
    $display("dl_test done");
  endtask
  task automatic bypass_test();
    int n0;
    bus(1'b0, 5'h10, 32'h0);
    n0 = rv;
    @(posedge clk);
    byp <= 1'b1;
    wait_for(5, 1'b1, 20);
    rchk(5'h10, n0 + 1);
    @(posedge clk);
    byp <= 1'b0;
    wait_for(5, 1'b0, 20);
    rchk(5'h10, n0 + 2);
    bus(1'b1, 5'h00, 32'h1);
    wait_for(2, 1'b1, 20);
    check(idle, 1'b0);
    @(posedge clk);
    byp <= 1'b1;
    wait_for(2, 1'b0, 20);
    $display("bypass_test done");
  endtask
  // ==========================================================
  // Clock, sequence and time limit
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial
  begin
    rst_n = 1'b0;
    {rd, wr, ack, spd0, spdl, byp} = 6'h0;
    {pfail, efault} = 2'h0;
    {addr, wdata, drv, press} = '0;
    {st1, st2} = 2'h3;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    reg_test();
    stuck_test();
    penalty_test();
    suppress_test();
    dl_test();
    bypass_test();
    stop_test();
  end
  initial
  begin
    repeat (60000) @(posedge clk);
    n_errors++;
    stop_test();
  end
endmodule
bind cvs_top cvs_checker chk_u (.REF_CLK, .RST_N, .AVS_READ, .AVS_WRITE, .AVS_READDATA,
  .AVS_WAITREQUEST, .WARN_LAMP, .BUZZER, .PENALTY_BRAKE, .ENGINE_IDLE_DEMAND, .ACTIVE_LED,
  .BYPASS_LED, .TRAIL_LED, .SEG_DIGITS);
`default_nettype wire
